// >>> hw/scq_pkg.sv
// Purpose: Shared constants for the slotted QAM symbol port
// Assumes: 100 MHz system clock on both ends
// Notes: Widths, levels, slot limits, register map of the source end
package scq_pkg;
  // Link word and FIFO shape
  localparam int WORD_W = 10;
  localparam int HALF_W = 5;
  localparam int SAMP_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] RDY_LEVEL = 5'h8;
  localparam logic [4:0] START_LEVEL = 5'h8;
  localparam logic [4:0] FULL_LEVEL = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h1;
  localparam logic [3:0] PTR_ONE = 4'h1;
  // Slot numbering
  localparam int SLOT_W = 8;
  localparam logic [7:0] SLOT_MUTE = 8'h00;
  localparam logic [7:0] SLOT_FIRST = 8'h01;
  localparam logic [7:0] SLOT_ONE = 8'h01;
  localparam logic [7:0] SLOT_MIN = 8'h10;
  localparam logic [7:0] SLOT_MAX = 8'hAC;
  localparam logic [1:0] SLOT_STEP_MASK = 2'h3;
  // Word width per mapping mode
  typedef enum logic [1:0] {
    MODE_QAM64 = 2'b00,
    MODE_QAM256 = 2'b01,
    MODE_BYPASS = 2'b10
  } scq_mode_e;
  localparam logic [9:0] MASK_QAM64 = 10'h03F;
  localparam logic [9:0] MASK_QAM256 = 10'h0FF;
  localparam logic [9:0] MASK_BYPASS = 10'h3FF;
  // Link timing seen by the source end
  localparam int SYS_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int LINK_QTR_CYC = LINK_HALF_CYC / 2;
  // Source end register map
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CNT_LSB = 8;
  localparam int TX_SLOT_LSB = 16;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Legal slot count: 16..172 in steps of four, else the minimum
  function automatic logic [7:0] slot_count_eff(input logic [7:0] req);
    if (req >= SLOT_MIN && req <= SLOT_MAX && (req[1:0] & SLOT_STEP_MASK) == 2'h0) begin
      return req;
    end
    return SLOT_MIN;
  endfunction

  // Slot after the current one, wrapping at the frame length
  function automatic logic [7:0] slot_after(input logic [7:0] cur, input logic [7:0] cnt);
    return (cur >= cnt) ? SLOT_FIRST : cur + SLOT_ONE;
  endfunction
endpackage

// >>> hw/scq_link_if.sv
// Purpose: Link between symbol source and slotted port device
// Assumes: Source end makes the port clock
// Notes: Plain wires, no clocking block
`timescale 1ns/1ps
`default_nettype none
interface scq_link_if;
  logic port_clk;
  logic frame_start_pulse;
  logic [scq_pkg::WORD_W-1:0] data;
  logic valid;
  logic parity;
  logic ready;

  modport device (
    input port_clk, frame_start_pulse, data, valid, parity,
    output ready
  );
  modport source (
    output port_clk, frame_start_pulse, data, valid, parity,
    input ready
  );
endinterface
`default_nettype wire

// >>> hw/scq_port_dev.sv
// Purpose: Device end: slot tagging, per-channel FIFOs, error flags
// Assumes: Port pins sampled by clk_sys_i; symbol side reads on clk_sys_i
// Notes: Ready for a slot is driven just after that slot is captured
`timescale 1ns/1ps
`default_nettype none
module scq_port_dev #(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link to the source
  scq_link_if.device lnk,
  // Configuration
  input wire logic [7:0] cfg_slot_count_i,
  input wire logic [NUM_CH-1:0][7:0] cfg_ch_slot_i,
  input wire logic [1:0] cfg_mode_i,
  input wire logic cfg_offset_i,
  // Symbol side reads
  input wire logic [NUM_CH-1:0] sym_rd_i,
  output logic [NUM_CH-1:0] sym_valid_o,
  output logic [NUM_CH-1:0][scq_pkg::SAMP_W-1:0] sym_data_o,
  // Error flags
  input wire logic [NUM_CH-1:0] ovf_clr_i,
  input wire logic unf_rd_i,
  input wire logic par_clr_i,
  output logic [NUM_CH-1:0] ovf_err_o,
  output logic [NUM_CH-1:0] unf_err_o,
  output logic par_err_o,
  output logic irq_n_o
);
  localparam int LW = scq_pkg::WORD_W + 4;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [LW-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
  logic pclk_prev_reg;
  logic pclk_s, fsp_s, valid_s, par_s;
  logic [scq_pkg::WORD_W-1:0] data_s;

  assign pin_raw = {lnk.port_clk, lnk.frame_start_pulse, lnk.valid, lnk.parity, lnk.data};
  assign {pclk_s, fsp_s, valid_s, par_s, data_s} = pin_s2_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pclk_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pclk_prev_reg <= pclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Slot tagging, FIFOs and flags
  logic [7:0] slot_reg, slot_next, slot_cur, cnt_eff;
  logic rdy_reg, rdy_next;
  logic [NUM_CH-1:0][scq_pkg::FIFO_DEPTH-1:0][scq_pkg::WORD_W-1:0] mem_reg, mem_next;
  logic [NUM_CH-1:0][scq_pkg::PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [NUM_CH-1:0][scq_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [NUM_CH-1:0] started_reg, started_next;
  logic [NUM_CH-1:0] sv_reg, sv_next, ovf_reg, ovf_next, unf_reg, unf_next;
  logic [NUM_CH-1:0][scq_pkg::SAMP_W-1:0] sd_reg, sd_next;
  logic par_reg, par_next, irq_n_reg, irq_n_next;
  logic edge_s, rise_s, hit, wr, rd;
  logic [NUM_CH-1:0] ovf_set, unf_set;
  logic [9:0] mask, word;
  logic [4:0] inc, dec;

  assign edge_s = pclk_s ^ pclk_prev_reg;
  assign rise_s = pclk_s & ~pclk_prev_reg;
  assign cnt_eff = scq_pkg::slot_count_eff(cfg_slot_count_i);

  // Mode sets how many low bits of the word are kept
  always_comb begin
    unique case (scq_pkg::scq_mode_e'(cfg_mode_i))
      scq_pkg::MODE_QAM64: mask = scq_pkg::MASK_QAM64;
      scq_pkg::MODE_QAM256: mask = scq_pkg::MASK_QAM256;
      scq_pkg::MODE_BYPASS: mask = scq_pkg::MASK_BYPASS;
      default: mask = scq_pkg::MASK_BYPASS;
    endcase
  end

  // Next state of the whole port
  always_comb begin
    slot_next = slot_reg;
    slot_cur = slot_reg;
    rdy_next = rdy_reg;
    par_next = par_reg & ~par_clr_i;
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    started_next = started_reg;
    sv_next = '0;
    sd_next = sd_reg;
    ovf_set = '0;
    unf_set = '0;
    hit = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    inc = '0;
    dec = '0;
    word = data_s & mask;
    // Every edge is a slot; frame start on a rising edge restarts
    if (edge_s) begin
      if (rise_s && fsp_s) begin
        slot_cur = scq_pkg::SLOT_FIRST;
      end else if (slot_reg != scq_pkg::SLOT_MUTE) begin
        slot_cur = scq_pkg::slot_after(slot_reg, cnt_eff);
      end
      slot_next = slot_cur;
      rdy_next = 1'b0;
      if (valid_s && (^{par_s, data_s})) begin
        par_next = 1'b1;
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Slot zero never matches: channel is muted
      hit = edge_s && slot_cur != scq_pkg::SLOT_MUTE && cfg_ch_slot_i[c] == slot_cur;
      if (hit) begin
        rdy_next = cnt_reg[c] < scq_pkg::RDY_LEVEL;
      end
      wr = hit && valid_s;
      if (wr && cnt_reg[c] == scq_pkg::FULL_LEVEL) begin
        wr = 1'b0;
        ovf_set[c] = 1'b1;
      end
      if (wr) begin
        mem_next[c][wptr_reg[c]] = word;
        wptr_next[c] = wptr_reg[c] + scq_pkg::PTR_ONE;
      end
      rd = 1'b0;
      // Reads before the FIFO has started are ignored silently
      if (sym_rd_i[c] && started_reg[c]) begin
        if (cnt_reg[c] == '0) begin
          unf_set[c] = 1'b1;
          started_next[c] = 1'b0;
        end else begin
          rd = 1'b1;
          sv_next[c] = 1'b1;
          // Q in the high half, I in the low, offset bit below each
          sd_next[c] = {mem_reg[c][rptr_reg[c]][scq_pkg::WORD_W-1:scq_pkg::HALF_W], cfg_offset_i,
                        mem_reg[c][rptr_reg[c]][scq_pkg::HALF_W-1:0], cfg_offset_i};
          rptr_next[c] = rptr_reg[c] + scq_pkg::PTR_ONE;
        end
      end
      inc = wr ? scq_pkg::CNT_ONE : '0;
      dec = rd ? scq_pkg::CNT_ONE : '0;
      cnt_next[c] = cnt_reg[c] + inc - dec;
      if (!started_reg[c] && cnt_next[c] >= scq_pkg::START_LEVEL) begin
        started_next[c] = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle
    ovf_next = (ovf_reg & ~ovf_clr_i) | ovf_set;
    unf_next = (unf_reg & ~{NUM_CH{unf_rd_i}}) | unf_set;
    if (edge_s && valid_s && (^{par_s, data_s})) begin
      par_next = 1'b1;
    end
    irq_n_next = ~(|ovf_next | |unf_next | par_next);
  end

  // Registers of the port
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_reg <= scq_pkg::SLOT_MUTE;
      rdy_reg <= 1'b0;
      mem_reg <= '0;
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      started_reg <= '0;
      sv_reg <= '0;
      sd_reg <= '0;
      ovf_reg <= '0;
      unf_reg <= '0;
      par_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      slot_reg <= slot_next;
      rdy_reg <= rdy_next;
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      started_reg <= started_next;
      sv_reg <= sv_next;
      sd_reg <= sd_next;
      ovf_reg <= ovf_next;
      unf_reg <= unf_next;
      par_reg <= par_next;
      irq_n_reg <= irq_n_next;
    end
  end

  // Outputs straight from registers
  assign lnk.ready = rdy_reg;
  assign sym_valid_o = sv_reg;
  assign sym_data_o = sd_reg;
  assign ovf_err_o = ovf_reg;
  assign unf_err_o = unf_reg;
  assign par_err_o = par_reg;
  assign irq_n_o = irq_n_reg;
endmodule
`default_nettype wire

// >>> hw/scq_port_src.sv
// Purpose: Source end: makes the port clock, frames, sends one word per order
// Assumes: Software orders words over AXI4-Lite
// Notes: Data changes a quarter period before each port clock edge
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scq_port_src (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link to the device
  scq_link_if.source lnk,
  // AXI4-Lite slave
  input wire logic [scq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [scq_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [7:0] HALF_M1 = 8'(scq_pkg::LINK_HALF_CYC - 1);
  localparam logic [7:0] QTR_M1 = 8'(scq_pkg::LINK_QTR_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // Ready synchroniser
  logic rdy_s1_reg, rdy_s2_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
    end else begin
      rdy_s1_reg <= lnk.ready;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registers, bus handshake and link sequencer
  logic [scq_pkg::AXI_AW-1:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic awg_reg, awg_next, wg_reg, wg_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic en_reg, en_next, pend_reg, pend_next, seen_reg, seen_next;
  logic [7:0] cnt_cfg_reg, cnt_cfg_next, txs_reg, txs_next;
  logic [9:0] txw_reg, txw_next, dat_reg, dat_next;
  logic [7:0] div_reg, div_next, slot_reg, slot_next, last_reg, last_next;
  logic pclk_reg, pclk_next, fsp_reg, fsp_next, val_reg, val_next, par_reg, par_next;
  logic awr_reg, awr_next, wrd_reg, wrd_next, arr_reg, arr_next;
  logic send;

  // Next state
  always_comb begin
    awa_next = awa_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    awg_next = awg_reg;
    wg_next = wg_reg;
    bv_next = bv_reg && !s_axi_bready;
    br_next = br_reg;
    rv_next = rv_reg && !s_axi_rready;
    rr_next = rr_reg;
    en_next = en_reg;
    pend_next = pend_reg;
    seen_next = seen_reg;
    cnt_cfg_next = cnt_cfg_reg;
    txs_next = txs_reg;
    txw_next = txw_reg;
    dat_next = dat_reg;
    div_next = (div_reg == HALF_M1) ? 8'h00 : div_reg + 8'h01;
    slot_next = slot_reg;
    last_next = last_reg;
    pclk_next = pclk_reg;
    fsp_next = fsp_reg;
    val_next = val_reg;
    par_next = par_reg;
    send = 1'b0;
    // Address and data taken in either order
    if (s_axi_awvalid && !awg_reg && !bv_reg) begin
      awg_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wg_reg && !bv_reg) begin
      wg_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (awg_reg && wg_reg && !bv_reg) begin
      awg_next = 1'b0;
      wg_next = 1'b0;
      bv_next = 1'b1;
      br_next = scq_pkg::RESP_OKAY;
      if (awa_reg == scq_pkg::REG_CTRL) begin
        en_next = wd_reg[scq_pkg::CTRL_EN_BIT];
        cnt_cfg_next = wd_reg[scq_pkg::CTRL_CNT_LSB +: 8];
      end else if (awa_reg == scq_pkg::REG_TX) begin
        // An order while one is pending is dropped
        if (!pend_reg) begin
          pend_next = 1'b1;
          txw_next = wd_reg[scq_pkg::WORD_W-1:0];
          txs_next = wd_reg[scq_pkg::TX_SLOT_LSB +: 8];
        end
      end else if (awa_reg != scq_pkg::REG_STAT) begin
        br_next = scq_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = scq_pkg::RESP_OKAY;
      rd_next = 32'h0000_0000;
      if (s_axi_araddr == scq_pkg::REG_CTRL) begin
        rd_next[scq_pkg::CTRL_EN_BIT] = en_reg;
        rd_next[scq_pkg::CTRL_CNT_LSB +: 8] = cnt_cfg_reg;
      end else if (s_axi_araddr == scq_pkg::REG_TX) begin
        rd_next[scq_pkg::WORD_W-1:0] = txw_reg;
        rd_next[scq_pkg::TX_SLOT_LSB +: 8] = txs_reg;
      end else if (s_axi_araddr == scq_pkg::REG_STAT) begin
        rd_next[scq_pkg::STAT_PEND_BIT] = pend_reg;
        rd_next[scq_pkg::STAT_RDY_BIT] = seen_reg;
      end else begin
        rr_next = scq_pkg::RESP_SLVERR;
      end
    end
    // Ready flags registered so the bus sees flip-flop outputs
    awr_next = !awg_next && !bv_next;
    wrd_next = !wg_next && !bv_next;
    arr_next = !rv_next;
    // Quarter period before an edge: set up that slot's pins
    if (div_reg == QTR_M1) begin
      send = en_reg && pend_reg && slot_reg == txs_reg && slot_reg != scq_pkg::SLOT_MUTE;
      val_next = send;
      fsp_next = en_reg && slot_reg == scq_pkg::SLOT_FIRST;
      if (send) begin
        pend_next = 1'b0;
        dat_next = txw_reg;
        par_next = ^txw_reg;
      end
    end
    // Port clock edge; ready of the previous slot is settled now
    if (div_reg == HALF_M1) begin
      pclk_next = ~pclk_reg;
      last_next = slot_reg;
      slot_next = scq_pkg::slot_after(slot_reg, scq_pkg::slot_count_eff(cnt_cfg_reg));
      if (last_reg == txs_reg) begin
        seen_next = rdy_s2_reg;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awa_reg <= '0;
      wd_reg <= '0;
      rd_reg <= '0;
      awg_reg <= 1'b0;
      wg_reg <= 1'b0;
      bv_reg <= 1'b0;
      br_reg <= '0;
      rv_reg <= 1'b0;
      rr_reg <= '0;
      en_reg <= 1'b0;
      pend_reg <= 1'b0;
      seen_reg <= 1'b0;
      cnt_cfg_reg <= scq_pkg::SLOT_MIN;
      txs_reg <= scq_pkg::SLOT_MUTE;
      txw_reg <= '0;
      dat_reg <= '0;
      div_reg <= '0;
      slot_reg <= scq_pkg::SLOT_FIRST;
      last_reg <= scq_pkg::SLOT_MUTE;
      pclk_reg <= 1'b0;
      fsp_reg <= 1'b0;
      val_reg <= 1'b0;
      par_reg <= 1'b0;
      awr_reg <= 1'b1;
      wrd_reg <= 1'b1;
      arr_reg <= 1'b1;
    end else begin
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      awg_reg <= awg_next;
      wg_reg <= wg_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rr_reg <= rr_next;
      en_reg <= en_next;
      pend_reg <= pend_next;
      seen_reg <= seen_next;
      cnt_cfg_reg <= cnt_cfg_next;
      txs_reg <= txs_next;
      txw_reg <= txw_next;
      dat_reg <= dat_next;
      div_reg <= div_next;
      slot_reg <= slot_next;
      last_reg <= last_next;
      pclk_reg <= pclk_next;
      fsp_reg <= fsp_next;
      val_reg <= val_next;
      par_reg <= par_next;
      awr_reg <= awr_next;
      wrd_reg <= wrd_next;
      arr_reg <= arr_next;
    end
  end

  // Outputs from registers
  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wrd_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign lnk.port_clk = pclk_reg;
  assign lnk.frame_start_pulse = fsp_reg;
  assign lnk.data = dat_reg;
  assign lnk.valid = val_reg;
  assign lnk.parity = par_reg;
endmodule
`default_nettype wire

// >>> verif/scq_link_chk.sv
// Purpose: Checker on the wires between source and device ends
// Assumes: Source makes the port clock, 8 system clocks per half period
// Notes: Sees only the link signals, instantiated beside the link
`timescale 1ns/1ps
`default_nettype none
module scq_link_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link wires
  input wire logic port_clk,
  input wire logic frame_start_pulse,
  input wire logic [scq_pkg::WORD_W-1:0] data,
  input wire logic valid,
  input wire logic parity,
  input wire logic ready
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////
  // Pins move a quarter period ahead of the clock so both edges see settled data
  sequence qtr_s;
    ##4 $changed(port_clk);
  endsequence
  sequence fsp_hold_s;
    frame_start_pulse [*7] ##1 !frame_start_pulse;
  endsequence
  // Port clock rhythm and pin timing
  clk_half_a: assert property ($changed(port_clk) |=> !$changed(port_clk) [*7] ##1 $changed(port_clk))
    else $error("port clock half period wrong");
  data_qtr_a: assert property ($changed(data) |-> qtr_s)
    else $error("data not a quarter ahead of clock");
  valid_qtr_a: assert property ($changed(valid) |-> qtr_s)
    else $error("valid not a quarter ahead of clock");
  fsp_rise_a: assert property ($rose(frame_start_pulse) |-> ##4 $rose(port_clk))
    else $error("frame start not around a rising edge");
  fsp_width_a: assert property ($rose(frame_start_pulse) |=> fsp_hold_s)
    else $error("frame start width wrong");
  // Parity travels with its word
  par_even_a: assert property (valid |-> !(^{parity, data}))
    else $error("odd parity on valid word");
  par_data_a: assert property ($changed(parity) |-> $changed(data))
    else $error("parity moved without data");
  // Ready follows a captured slot by a fixed lag
  rdy_lag_a: assert property ($changed(ready) |-> $past(port_clk, 3) != $past(port_clk, 4))
    else $error("ready moved outside slot lag");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench joining source and device ends
// Assumes: 100 MHz clock, software drives source over AXI4-Lite
// Notes: Channel 0 on slot 3, channel 2 muted
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] SLOT_CH0 = 8'h03;
  localparam logic [9:0] MSK [3] = '{scq_pkg::MASK_QAM64, scq_pkg::MASK_QAM256, scq_pkg::MASK_BYPASS};
  logic clk_sys_i;
  logic rstn_i;
  logic [3:0] aw_a, ar_a, ovf_clr_i, sym_rd_i, sym_valid_o, ovf_err_o, unf_err_o;
  logic aw_v, w_v, b_rdy, ar_v, r_rdy, aw_r, w_r, b_v, ar_r, r_v;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp, cfg_mode_i;
  logic cfg_offset_i, unf_rd_i, par_err_o, irq_n_o;
  logic [3:0][11:0] sym_data_o;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////
  // Ends, link and checker
  scq_link_if lnk ();
  scq_port_dev u_scq_port_dev (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lnk(lnk), .cfg_slot_count_i(8'h10),
    .cfg_ch_slot_i({8'h10, 8'h00, 8'h04, SLOT_CH0}), .cfg_mode_i(cfg_mode_i), .cfg_offset_i(cfg_offset_i),
    .sym_rd_i(sym_rd_i), .sym_valid_o(sym_valid_o), .sym_data_o(sym_data_o), .ovf_clr_i(ovf_clr_i),
    .unf_rd_i(unf_rd_i), .par_clr_i(1'b0), .ovf_err_o(ovf_err_o), .unf_err_o(unf_err_o), .par_err_o(par_err_o),
    .irq_n_o(irq_n_o));
  scq_port_src u_scq_port_src (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lnk(lnk), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy));
  scq_link_chk u_scq_link_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .port_clk(lnk.port_clk),
    .frame_start_pulse(lnk.frame_start_pulse), .data(lnk.data), .valid(lnk.valid), .parity(lnk.parity),
    .ready(lnk.ready));
  ////////////////////////////////////////////////////////////
  // Report and verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bus cycles: hold each channel until its own handshake edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v) break;
    end
    r = b_resp;
    b_rdy <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v) break;
    end
    d = r_d;
    r = r_resp;
    r_rdy <= 1'b0;
  endtask
  // One word on one slot; waits for it to leave, then a frame for ready to settle
  task automatic send(input logic [7:0] s, input logic [9:0] w);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(scq_pkg::REG_TX, {8'h00, s, 6'h00, w}, r);
    d = 32'h0000_0001;
    for (int i = 0; i < 300 && d[scq_pkg::STAT_PEND_BIT]; i++) axi_rd(scq_pkg::REG_STAT, d, r);
    chk("tx sent", 1'b0, d[scq_pkg::STAT_PEND_BIT]);
    repeat (200) @(posedge clk_sys_i);
  endtask
  // Symbol read, answer looked at in its one valid cycle
  task automatic rd_sym(input int ch, input logic v, input logic [11:0] e);
    @(posedge clk_sys_i);
    sym_rd_i[ch] <= 1'b1;
    @(posedge clk_sys_i);
    sym_rd_i[ch] <= 1'b0;
    #1;
    chk("sym valid", v, sym_valid_o[ch]);
    if (v) chk("sym data", e, sym_data_o[ch]);
  endtask
  function automatic logic [11:0] samp(input int m, input logic [9:0] w);
    logic [9:0] k;
    k = w & MSK[m];
    return {k[9:5], m[0], k[4:0], m[0]};
  endfunction
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    #1;
    chk("irq idle", 1'b1, irq_n_o);
    chk("flags idle", 9'h000, {ovf_err_o, unf_err_o, par_err_o});
    axi_rd(scq_pkg::REG_CTRL, d, r);
    chk("ctrl reset", 32'h0000_1000, d);
    axi_rd(4'hC, d, r);
    chk("unmapped rd resp", scq_pkg::RESP_SLVERR, r);
    chk("unmapped rd data", 32'h0000_0000, d);
    axi_wr(4'hC, 32'h0000_FFFF, r);
    chk("unmapped wr resp", scq_pkg::RESP_SLVERR, r);
    axi_wr(scq_pkg::REG_CTRL, 32'h0000_1001, r);
    chk("ctrl wr resp", scq_pkg::RESP_OKAY, r);
    // A word sent before the device has seen a frame start is lost, so let one frame pass
    repeat (150) @(posedge clk_sys_i);
  endtask
  task automatic t_modes();
    logic [31:0] d;
    logic [1:0] r;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys_i);
      cfg_mode_i <= m[1:0];
      cfg_offset_i <= m[0];
      for (int i = 0; i < 8; i++) begin
        send(SLOT_CH0, 10'h2B5 ^ {2{i[4:0]}});
        axi_rd(scq_pkg::REG_STAT, d, r);
        chk("ready seen", i < 7, d[scq_pkg::STAT_RDY_BIT]);
        if (i == 6) begin
          rd_sym(0, 1'b0, 12'h000);
          chk("no early underflow", 4'h0, unf_err_o);
        end
      end
      for (int i = 0; i < 8; i++) rd_sym(0, 1'b1, samp(m, 10'h2B5 ^ {2{i[4:0]}}));
      rd_sym(0, 1'b0, 12'h000);
      chk("underflow", 4'h1, unf_err_o);
      chk("irq underflow", 1'b0, irq_n_o);
      @(posedge clk_sys_i);
      unf_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      unf_rd_i <= 1'b0;
      #1;
      chk("underflow clear", 4'h0, unf_err_o);
      chk("irq release", 1'b1, irq_n_o);
    end
  endtask
  task automatic t_overflow();
    for (int i = 0; i < 17; i++) begin
      send(SLOT_CH0, 10'h100 + 10'(i));
      if (i == 15) chk("no overflow yet", 4'h0, ovf_err_o);
    end
    chk("overflow", 4'h1, ovf_err_o);
    chk("irq overflow", 1'b0, irq_n_o);
    @(posedge clk_sys_i);
    ovf_clr_i <= 4'h1;
    @(posedge clk_sys_i);
    ovf_clr_i <= 4'h0;
    #1;
    chk("overflow clear", 4'h0, ovf_err_o);
    for (int i = 0; i < 16; i++) rd_sym(0, 1'b1, samp(2, 10'h100 + 10'(i)));
    rd_sym(2, 1'b0, 12'h000);
    chk("muted quiet", 5'h00, {unf_err_o, par_err_o});
  endtask
  ////////////////////////////////////////////////////////////
  // Clock, hang guard, main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {rstn_i, aw_v, w_v, b_rdy, ar_v, r_rdy, cfg_offset_i, unf_rd_i} = '0;
    {aw_a, ar_a, ovf_clr_i, sym_rd_i, w_d, cfg_mode_i} = '0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_modes();
    t_overflow();
    finish_test();
  end
endmodule
`default_nettype wire
